// >>> mct_regs.svh
// Register offsets, trigger values and halt codes of the maintenance command bank.
// Assumes Modbus holding-register addressing: each command is an upper/lower register pair.
`ifndef MCT_REGS_SVH
`define MCT_REGS_SVH

// ************************************************************
// Upper register address of each command pair
// ************************************************************
`define MCT_OFS_ALARM_CLEAR 16'h0180
`define MCT_OFS_ALARM_LOG_CLEAR 16'h0184
`define MCT_OFS_COMM_FAULT_LOG_CLEAR 16'h0188
`define MCT_OFS_DEMAND_POSITION_PRESET 16'h018a
`define MCT_OFS_PARAMETER_RECALC 16'h018c
`define MCT_OFS_PARTIAL_DEFAULTS 16'h018e
`define MCT_OFS_BULK_LOAD_FROM_NV 16'h0190
`define MCT_OFS_BULK_STORE_TO_NV 16'h0192
`define MCT_OFS_FULL_DEFAULTS 16'h0194
`define MCT_OFS_LATCH_INFO_CLEAR 16'h019a
`define MCT_OFS_SEQUENCE_LOG_CLEAR 16'h019c
`define MCT_OFS_BOTH_DISTANCE_CLEAR 16'h019e
`define MCT_OFS_TORQUE_OFF_RELEASE 16'h01a0
`define MCT_OFS_INDEX_POSITION_SET 16'h01a2
`define MCT_OFS_INDEX_POSITION_DISCARD 16'h01a4
`define MCT_OFS_INFO_CLEAR 16'h01a6
`define MCT_OFS_INFO_LOG_CLEAR 16'h01a8
`define MCT_OFS_ENERGY_TOTAL_CLEAR 16'h01ac
`define MCT_OFS_DISTANCE0_CLEAR 16'h01ae
`define MCT_OFS_DISTANCE1_CLEAR 16'h01b0
`define MCT_OFS_LINK_RECONFIGURE 16'h01bc
`define MCT_OFS_HALT_MOTION 16'h01be
`define MCT_LOWER_STEP 16'h0001

// ************************************************************
// Command values
// ************************************************************
`define MCT_VALUE_IDLE 32'h0000_0000
`define MCT_TRIG_EDGE 32'h0000_0001
`define MCT_TRIG_AUTO 32'h0000_0002
`define MCT_HALT_FIRST 32'h0000_0001
`define MCT_HALT_LAST 32'h0000_0004
`define MCT_HALT_CODE_HI 2
`define MCT_LINK_RELOAD_ALL 10'h3ff
`define MCT_RDATA_UNMAPPED 16'h0000

`endif

// >>> mct_pkg.sv
// Types shared by the maintenance command bank and its command slots.
// Assumes mct_regs.svh supplies the numeric constants.
package mct_pkg;

    // ************************************************************
    // Command slots
    // ************************************************************
    typedef enum logic [4:0] {
        MCT_SLOT_ALARM_CLEAR = 5'h00,
        MCT_SLOT_ALARM_LOG_CLEAR = 5'h01,
        MCT_SLOT_COMM_FAULT_LOG_CLEAR = 5'h02,
        MCT_SLOT_POSITION_PRESET = 5'h03,
        MCT_SLOT_PARAM_RECALC = 5'h04,
        MCT_SLOT_PARTIAL_DEFAULTS = 5'h05,
        MCT_SLOT_BULK_LOAD = 5'h06,
        MCT_SLOT_BULK_STORE = 5'h07,
        MCT_SLOT_FULL_DEFAULTS = 5'h08,
        MCT_SLOT_LATCH_INFO_CLEAR = 5'h09,
        MCT_SLOT_SEQUENCE_LOG_CLEAR = 5'h0a,
        MCT_SLOT_BOTH_DISTANCE_CLEAR = 5'h0b,
        MCT_SLOT_TORQUE_OFF_RELEASE = 5'h0c,
        MCT_SLOT_INDEX_POSITION_SET = 5'h0d,
        MCT_SLOT_INDEX_POSITION_DISCARD = 5'h0e,
        MCT_SLOT_INFO_CLEAR = 5'h0f,
        MCT_SLOT_INFO_LOG_CLEAR = 5'h10,
        MCT_SLOT_ENERGY_TOTAL_CLEAR = 5'h11,
        MCT_SLOT_DISTANCE0_CLEAR = 5'h12,
        MCT_SLOT_DISTANCE1_CLEAR = 5'h13,
        MCT_SLOT_LINK_RECONFIGURE = 5'h14,
        MCT_SLOT_HALT_MOTION = 5'h15
    } mct_slot_t;

    // ************************************************************
    // Halt methods and link reconfiguration states
    // ************************************************************
    typedef enum logic [2:0] {
        MCT_HALT_NONE = 3'h0,
        MCT_HALT_IMMEDIATE = 3'h1,
        MCT_HALT_DECELERATE = 3'h2,
        MCT_HALT_QUICK_HALT = 3'h3,
        MCT_HALT_STOP_INPUT = 3'h4
    } mct_halt_t;

    typedef enum logic [2:0] {
        MCT_LINK_IDLE = 3'b001,
        MCT_LINK_SAMPLE = 3'b010,
        MCT_LINK_RELOAD = 3'b100
    } mct_link_state_t;

endpackage

// >>> mct_slot_if.sv
// Carrier between the command bank and one command slot.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface mct_slot_if;
    logic wr_hi;
    logic wr_lo;
    logic [15:0] wdata;
    logic [31:0] value;
    logic fire;
    logic [2:0] stop_code;

    modport ctrl (
        output wr_hi,
        output wr_lo,
        output wdata,
        input value,
        input fire,
        input stop_code
    );

    modport slot (
        input wr_hi,
        input wr_lo,
        input wdata,
        output value,
        output fire,
        output stop_code
    );
endinterface

// >>> mct_cmd_slot.sv
// One maintenance command register pair and its trigger evaluation.
// Assumes the bank writes the upper half before the lower half of a pair.
`timescale 1ns/1ps
`include "mct_regs.svh"

module mct_cmd_slot #(
    parameter bit IS_STOP = 1'b0
) (
    input wire logic i_mclk, // System clock.
    input wire logic i_rst_n, // Asynchronous reset, active low.
    mct_slot_if.slot bus       // Access from the bank.
);
    logic [15:0] hi_stage;
    logic [31:0] next_value;

    // The upper half waits here so the trigger sees the whole word at once.
    assign next_value = {hi_stage, bus.wdata};

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hi_stage <= 16'h0000;
        end else if (bus.wr_hi) begin
            hi_stage <= bus.wdata;
        end
    end

    // ************************************************************
    // Trigger evaluation
    // ************************************************************
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.value <= `MCT_VALUE_IDLE;
            bus.fire <= 1'b0;
            bus.stop_code <= 3'h0;
        end else begin
            bus.fire <= 1'b0;
            if (IS_STOP) begin
                if (bus.wr_lo) begin
                    if (next_value >= `MCT_HALT_FIRST && next_value <= `MCT_HALT_LAST) begin
                        bus.value <= next_value;
                        bus.fire <= 1'b1;
                        bus.stop_code <= next_value[`MCT_HALT_CODE_HI:0];
                    end else begin
                        bus.value <= `MCT_VALUE_IDLE;
                    end
                end else if (bus.fire) begin
                    // Cleared once the halt has been handed on.
                    bus.value <= `MCT_VALUE_IDLE;
                end
            end else if (bus.wr_lo) begin
                if (next_value == `MCT_TRIG_AUTO) begin
                    bus.fire <= 1'b1;
                    bus.value <= `MCT_TRIG_EDGE;
                end else begin
                    // Only a fresh zero to one change fires; repeated ones do not.
                    bus.fire <= (next_value == `MCT_TRIG_EDGE) &&
                                (bus.value == `MCT_VALUE_IDLE);
                    bus.value <= next_value;
                end
            end
        end
    end
endmodule // mct_cmd_slot

// >>> mct_cmd_bank.sv
// Maintenance command bank: register access from the Modbus frame handler and
// one-shot action pulses to the alarm, position, memory and link subsystems.
// Assumes a same-clock register port from the frame handler and async node select pins.
//
// Contract
// - Edge method fires only on zero to one.
// - Repeated ones never re-fire a command; the halt register fires again on each write of 1 to 4.
// - Writing two fires, then value becomes one.
// - Halt value picks immediate, decelerate, input.
// - Halt value three: quick halt, current kept.
// - Halt register clears to zero after execution.
// - Link reset samples node selects, then reconfigures.
// - Reconfiguration reloads all ten link parameters.
// - Alarm reset spares non-resettable alarms.
// - Bulk load copies memory into RAM.
// - Bulk store copies RAM into memory.
// - Partial defaults keep link settings.
// - Full defaults include link settings.
// - Combined and single distance counter clears.
// - Index position set and discard commands.
// - Position preset loads demand position.
// - Recalculation command re-sets parameters.
// - Release command exits torque-off latch.
// - Separate clears for logs and totals.
// - Every command register reads and writes.
`timescale 1ns/1ps
`include "mct_regs.svh"

module mct_cmd_bank #(
    parameter int SLOT_COUNT = 22,
    parameter int NODE_SELECT_WIDTH = 4,
    parameter int SYNC_STAGES = 3,
    parameter int LINK_PARAM_COUNT = 10
) (
    input wire logic i_mclk, // System clock, 100 MHz.
    input wire logic i_rst_n, // Asynchronous reset, active low.
    input wire logic i_reg_wr, // Register write strobe.
    input wire logic i_reg_rd, // Register read strobe.
    input wire logic [15:0] i_reg_addr, // Register address.
    input wire logic [15:0] i_reg_wdata, // Register write data.
    output logic [15:0] o_reg_rdata, // Register read data.
    output logic o_reg_rvalid, // Read data valid pulse.
    output logic o_reg_err, // Unmapped address pulse.
    input wire logic i_alarm_nonresettable, // Active alarm may not be reset.
    input wire logic [NODE_SELECT_WIDTH-1:0] i_node_select_inputs, // Node select pins.
    output logic o_alarm_clear, // Clear present alarm.
    output logic o_alarm_log_clear, // Clear alarm history.
    output logic o_comm_fault_log_clear, // Clear link error history.
    output logic o_position_preset, // Preset demand position.
    output logic o_param_recalc, // Recalculate parameters.
    output logic o_partial_defaults, // Defaults, link settings kept.
    output logic o_full_defaults, // Defaults, link settings too.
    output logic o_bulk_load, // Non-volatile to RAM copy.
    output logic o_bulk_store, // RAM to non-volatile copy.
    output logic o_latch_info_clear, // Clear latch information.
    output logic o_sequence_log_clear, // Clear sequence history.
    output logic [1:0] o_distance_clear, // Clear distance counters 1:0.
    output logic o_torque_off_release, // Leave torque-off latch.
    output logic o_index_position_set, // Re-set index position.
    output logic o_index_position_discard, // Discard re-set position.
    output logic o_info_clear, // Clear information.
    output logic o_info_log_clear, // Clear information history.
    output logic o_energy_total_clear, // Clear user energy total.
    output logic o_halt_req, // Halt request pulse.
    output mct_pkg::mct_halt_t o_halt_method, // Halt method of last request.
    output logic o_halt_keep_current, // Keep motor current on halt.
    output logic o_link_reload, // Reload link parameters pulse.
    output logic [LINK_PARAM_COUNT-1:0] o_link_reload_mask, // Parameters to reload.
    output logic [NODE_SELECT_WIDTH-1:0] o_network_index, // Sampled node select.
    output logic o_link_busy // Reconfiguration in progress.
);
    // ************************************************************
    // Address decode
    // ************************************************************
    localparam logic [15:0] UPPER_OFS [SLOT_COUNT] = '{
        `MCT_OFS_ALARM_CLEAR, `MCT_OFS_ALARM_LOG_CLEAR, `MCT_OFS_COMM_FAULT_LOG_CLEAR,
        `MCT_OFS_DEMAND_POSITION_PRESET, `MCT_OFS_PARAMETER_RECALC,
        `MCT_OFS_PARTIAL_DEFAULTS, `MCT_OFS_BULK_LOAD_FROM_NV, `MCT_OFS_BULK_STORE_TO_NV,
        `MCT_OFS_FULL_DEFAULTS, `MCT_OFS_LATCH_INFO_CLEAR, `MCT_OFS_SEQUENCE_LOG_CLEAR,
        `MCT_OFS_BOTH_DISTANCE_CLEAR, `MCT_OFS_TORQUE_OFF_RELEASE,
        `MCT_OFS_INDEX_POSITION_SET, `MCT_OFS_INDEX_POSITION_DISCARD, `MCT_OFS_INFO_CLEAR,
        `MCT_OFS_INFO_LOG_CLEAR, `MCT_OFS_ENERGY_TOTAL_CLEAR, `MCT_OFS_DISTANCE0_CLEAR,
        `MCT_OFS_DISTANCE1_CLEAR, `MCT_OFS_LINK_RECONFIGURE, `MCT_OFS_HALT_MOTION
    };

    // Returns {hit, lower half, slot index}.
    function automatic logic [6:0] decode(input logic [15:0] addr);
        logic [6:0] result;
        result = 7'h00;
        for (int k = 0; k < SLOT_COUNT; k++) begin
            if (addr == UPPER_OFS[k]) begin
                result = {1'b1, 1'b0, 5'(k)};
            end else if (addr == UPPER_OFS[k] + `MCT_LOWER_STEP) begin
                result = {1'b1, 1'b1, 5'(k)};
            end
        end
        return result;
    endfunction

    logic [6:0] wr_dec;
    logic [6:0] rd_dec;
    logic [SLOT_COUNT-1:0] fire;
    logic [31:0] slot_value [SLOT_COUNT];
    logic [2:0] halt_code;

    assign wr_dec = decode(i_reg_addr);
    assign rd_dec = decode(i_reg_addr);

    // ************************************************************
    // Command slots
    // ************************************************************
    mct_slot_if sif [SLOT_COUNT] ();

    for (genvar g = 0; g < SLOT_COUNT; g++) begin : g_slot
        assign sif[g].wr_hi = i_reg_wr && wr_dec[6] && !wr_dec[5] && (wr_dec[4:0] == 5'(g));
        assign sif[g].wr_lo = i_reg_wr && wr_dec[6] && wr_dec[5] && (wr_dec[4:0] == 5'(g));
        assign sif[g].wdata = i_reg_wdata;
        assign fire[g] = sif[g].fire;
        assign slot_value[g] = sif[g].value;

        mct_cmd_slot #(
            .IS_STOP(g == int'(mct_pkg::MCT_SLOT_HALT_MOTION))
        ) u_slot (
            .i_mclk(i_mclk),
            .i_rst_n(i_rst_n),
            .bus(sif[g].slot)
        );
    end

    assign halt_code = sif[int'(mct_pkg::MCT_SLOT_HALT_MOTION)].stop_code;

    // ************************************************************
    // Register read port
    // ************************************************************
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= `MCT_RDATA_UNMAPPED;
            o_reg_rvalid <= 1'b0;
            o_reg_err <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            o_reg_err <= (i_reg_rd && !rd_dec[6]) || (i_reg_wr && !wr_dec[6]);
            if (i_reg_rd) begin
                if (!rd_dec[6]) begin
                    o_reg_rdata <= `MCT_RDATA_UNMAPPED;
                end else if (rd_dec[5]) begin
                    o_reg_rdata <= slot_value[rd_dec[4:0]][15:0];
                end else begin
                    o_reg_rdata <= slot_value[rd_dec[4:0]][31:16];
                end
            end
        end
    end

    // ************************************************************
    // Action pulses
    // ************************************************************
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_alarm_clear <= 1'b0;
            o_alarm_log_clear <= 1'b0;
            o_comm_fault_log_clear <= 1'b0;
            o_latch_info_clear <= 1'b0;
            o_sequence_log_clear <= 1'b0;
            o_info_clear <= 1'b0;
            o_info_log_clear <= 1'b0;
            o_energy_total_clear <= 1'b0;
            o_distance_clear <= 2'b00;
        end else begin
            // A non-resettable alarm simply never sees the clear.
            o_alarm_clear <= fire[mct_pkg::MCT_SLOT_ALARM_CLEAR] && !i_alarm_nonresettable;
            o_alarm_log_clear <= fire[mct_pkg::MCT_SLOT_ALARM_LOG_CLEAR];
            o_comm_fault_log_clear <= fire[mct_pkg::MCT_SLOT_COMM_FAULT_LOG_CLEAR];
            o_latch_info_clear <= fire[mct_pkg::MCT_SLOT_LATCH_INFO_CLEAR];
            o_sequence_log_clear <= fire[mct_pkg::MCT_SLOT_SEQUENCE_LOG_CLEAR];
            o_info_clear <= fire[mct_pkg::MCT_SLOT_INFO_CLEAR];
            o_info_log_clear <= fire[mct_pkg::MCT_SLOT_INFO_LOG_CLEAR];
            o_energy_total_clear <= fire[mct_pkg::MCT_SLOT_ENERGY_TOTAL_CLEAR];
            o_distance_clear[0] <= fire[mct_pkg::MCT_SLOT_BOTH_DISTANCE_CLEAR] ||
                                   fire[mct_pkg::MCT_SLOT_DISTANCE0_CLEAR];
            o_distance_clear[1] <= fire[mct_pkg::MCT_SLOT_BOTH_DISTANCE_CLEAR] ||
                                   fire[mct_pkg::MCT_SLOT_DISTANCE1_CLEAR];
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_position_preset <= 1'b0;
            o_param_recalc <= 1'b0;
            o_torque_off_release <= 1'b0;
            o_index_position_set <= 1'b0;
            o_index_position_discard <= 1'b0;
        end else begin
            o_position_preset <= fire[mct_pkg::MCT_SLOT_POSITION_PRESET];
            o_param_recalc <= fire[mct_pkg::MCT_SLOT_PARAM_RECALC];
            o_torque_off_release <= fire[mct_pkg::MCT_SLOT_TORQUE_OFF_RELEASE];
            o_index_position_set <= fire[mct_pkg::MCT_SLOT_INDEX_POSITION_SET];
            o_index_position_discard <= fire[mct_pkg::MCT_SLOT_INDEX_POSITION_DISCARD];
        end
    end

    // Memory operations are only pulsed here; the memory subsystem owns pacing,
    // so closely spaced stores rely on the master leaving wider gaps.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_partial_defaults <= 1'b0;
            o_full_defaults <= 1'b0;
            o_bulk_load <= 1'b0;
            o_bulk_store <= 1'b0;
        end else begin
            o_partial_defaults <= fire[mct_pkg::MCT_SLOT_PARTIAL_DEFAULTS];
            o_full_defaults <= fire[mct_pkg::MCT_SLOT_FULL_DEFAULTS];
            o_bulk_load <= fire[mct_pkg::MCT_SLOT_BULK_LOAD];
            o_bulk_store <= fire[mct_pkg::MCT_SLOT_BULK_STORE];
        end
    end

    // ************************************************************
    // Halt request
    // ************************************************************
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_halt_req <= 1'b0;
            o_halt_method <= mct_pkg::MCT_HALT_NONE;
            o_halt_keep_current <= 1'b0;
        end else begin
            o_halt_req <= fire[mct_pkg::MCT_SLOT_HALT_MOTION];
            if (fire[mct_pkg::MCT_SLOT_HALT_MOTION]) begin
                o_halt_method <= mct_pkg::mct_halt_t'(halt_code);
                o_halt_keep_current <= (halt_code == mct_pkg::MCT_HALT_QUICK_HALT);
            end
        end
    end

    // ************************************************************
    // Node select synchroniser
    // ************************************************************
    logic [NODE_SELECT_WIDTH-1:0] ns_sync [SYNC_STAGES];
    logic [NODE_SELECT_WIDTH-1:0] ns_stable;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int s = 0; s < SYNC_STAGES; s++) begin
                ns_sync[s] <= '0;
            end
            ns_stable <= '0;
        end else begin
            ns_sync[0] <= i_node_select_inputs;
            for (int s = 1; s < SYNC_STAGES; s++) begin
                ns_sync[s] <= ns_sync[s-1];
            end
            // A change is taken only when the last two stages agree.
            if (ns_sync[SYNC_STAGES-2] == ns_sync[SYNC_STAGES-1]) begin
                ns_stable <= ns_sync[SYNC_STAGES-1];
            end
        end
    end

    // ************************************************************
    // Link reconfiguration sequence
    // ************************************************************
    mct_pkg::mct_link_state_t link_state;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            link_state <= mct_pkg::MCT_LINK_IDLE;
            o_link_reload <= 1'b0;
            o_link_reload_mask <= '0;
            o_network_index <= '0;
            o_link_busy <= 1'b0;
        end else begin
            o_link_reload <= 1'b0;
            unique case (link_state)
                mct_pkg::MCT_LINK_IDLE: begin
                    if (fire[mct_pkg::MCT_SLOT_LINK_RECONFIGURE]) begin
                        link_state <= mct_pkg::MCT_LINK_SAMPLE;
                        o_link_busy <= 1'b1;
                    end
                end
                mct_pkg::MCT_LINK_SAMPLE: begin
                    // Node selects are taken before any parameter is reloaded.
                    o_network_index <= ns_stable;
                    link_state <= mct_pkg::MCT_LINK_RELOAD;
                end
                mct_pkg::MCT_LINK_RELOAD: begin
                    o_link_reload <= 1'b1;
                    o_link_reload_mask <= LINK_PARAM_COUNT'(`MCT_LINK_RELOAD_ALL);
                    o_link_busy <= 1'b0;
                    link_state <= mct_pkg::MCT_LINK_IDLE;
                end
                default: begin
                    link_state <= mct_pkg::MCT_LINK_IDLE;
                    o_link_busy <= 1'b0;
                end
            endcase
        end
    end
endmodule // mct_cmd_bank

// >>> mct_cmd_bank_sva.sv
// Port assertions for the maintenance command bank.
// Assumes a bind to mct_cmd_bank from the testbench.
`timescale 1ns/1ps
module mct_cmd_bank_sva #(
    parameter int LINK_PARAM_COUNT = 10
) (
    input logic i_mclk, // Clock.
    input logic i_rst_n, // Reset.
    input logic i_reg_wr, // Write.
    input logic i_reg_rd, // Read.
    input logic [15:0] i_reg_addr, // Address.
    input logic i_alarm_nonresettable, // Alarm kind.
    input logic o_reg_rvalid, // Valid.
    input logic o_reg_err, // Unmapped.
    input logic o_alarm_clear, // Alarm clear.
    input logic [1:0] o_distance_clear, // Counters.
    input logic o_halt_req, // Halt.
    input mct_pkg::mct_halt_t o_halt_method, // Method.
    input logic o_halt_keep_current, // Current kept.
    input logic o_link_reload, // Reload.
    input logic [LINK_PARAM_COUNT-1:0] o_link_reload_mask, // Mask.
    input logic o_link_busy // Busy.
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    property p_rd_answer; i_reg_rd |=> o_reg_rvalid || o_reg_err; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read unanswered");
    property p_alarm_cause; o_alarm_clear |-> $past(i_reg_wr && i_reg_addr == 16'h0181, 2);
    endproperty
    a_alarm_cause: assert property (p_alarm_cause) else $error("stray alarm clear");
    property p_alarm_once; o_alarm_clear |=> !o_alarm_clear; endproperty
    a_alarm_once: assert property (p_alarm_once) else $error("alarm clear repeated");
    property p_alarm_keep; o_alarm_clear |-> !$past(i_alarm_nonresettable); endproperty
    a_alarm_keep: assert property (p_alarm_keep) else $error("alarm not kept");
    property p_halt_cause; o_halt_req |-> $past(i_reg_wr && i_reg_addr == 16'h01bf, 2);
    endproperty
    a_halt_cause: assert property (p_halt_cause) else $error("stray halt");
    property p_quick; o_halt_keep_current == (o_halt_method == mct_pkg::MCT_HALT_QUICK_HALT);
    endproperty
    a_quick: assert property (p_quick) else $error("current kept wrongly");
    property p_dist_both; o_distance_clear == 2'b11 |-> $past(i_reg_addr == 16'h019f, 2);
    endproperty
    a_dist_both: assert property (p_dist_both) else $error("counters cleared together");
    property p_busy; o_link_reload |-> $past(o_link_busy) && !o_link_busy; endproperty
    a_busy: assert property (p_busy) else $error("reload without sampling");
    property p_mask; o_link_reload |-> &o_link_reload_mask; endproperty
    a_mask: assert property (p_mask) else $error("partial reload");
endmodule // mct_cmd_bank_sva

// >>> mct_master_model.sv
// Serial-link master model issuing register strobes.
// Assumes one clock shared with the bank.
`timescale 1ns/1ps
module mct_master_model (
    input logic i_mclk, // Clock.
    input logic i_rvalid, // Read valid.
    input logic i_err, // Unmapped.
    input logic [15:0] i_rdata, // Read data.
    output logic o_wr = 1'b0, // Write.
    output logic o_rd = 1'b0, // Read.
    output logic [15:0] o_addr = 16'h0000, // Address.
    output logic [15:0] o_wdata = 16'h0000 // Data.
);
    // Released lines show the inverse of their last value.
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        if (a == 16'h0192) repeat (20) @(posedge i_mclk);
        @(posedge i_mclk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_mclk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge i_mclk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_mclk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1 d = (i_rvalid || i_err) ? i_rdata : 16'hxxxx;
    endtask
endmodule // mct_master_model

// >>> test_maintenance_command_trigger.sv
// Self-checking bench for the maintenance command bank.
// Assumes the package, design and models compile first.
`timescale 1ns/1ps
module test_maintenance_command_trigger;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic nonres = 1'b0;
    logic [3:0] nsel = 4'ha;
    logic wr, rd, rvalid, err, keep, busy;
    logic [15:0] addr, wdata, rdata;
    logic [20:0] p;
    logic [9:0] mask;
    logic [3:0] nidx;
    mct_pkg::mct_halt_t method;
    int err_count = 0;
    int checked = 0;
    localparam logic [15:0] OFS [21] = '{16'h0180, 16'h0184, 16'h0188, 16'h018a, 16'h018c,
        16'h018e, 16'h0190, 16'h0192, 16'h0194, 16'h019a, 16'h019c, 16'h019e, 16'h01a0,
        16'h01a2, 16'h01a4, 16'h01a6, 16'h01a8, 16'h01ac, 16'h01ae, 16'h01b0, 16'h01bc};
    always #5 i_mclk = ~i_mclk;
    mct_cmd_bank dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .o_reg_err(err), .i_alarm_nonresettable(nonres), .i_node_select_inputs(nsel),
        .o_alarm_clear(p[0]), .o_alarm_log_clear(p[1]), .o_comm_fault_log_clear(p[2]),
        .o_position_preset(p[3]), .o_param_recalc(p[4]), .o_partial_defaults(p[5]),
        .o_bulk_load(p[6]), .o_bulk_store(p[7]), .o_full_defaults(p[8]),
        .o_latch_info_clear(p[9]), .o_sequence_log_clear(p[10]), .o_distance_clear(p[18:17]),
        .o_torque_off_release(p[11]), .o_index_position_set(p[12]),
        .o_index_position_discard(p[13]), .o_info_clear(p[14]), .o_info_log_clear(p[15]),
        .o_energy_total_clear(p[16]), .o_link_reload(p[19]), .o_halt_req(p[20]),
        .o_halt_method(method), .o_halt_keep_current(keep), .o_link_reload_mask(mask),
        .o_network_index(nidx), .o_link_busy(busy));
    mct_master_model u_mst (.i_mclk(i_mclk), .i_rvalid(rvalid), .i_err(err), .i_rdata(rdata),
        .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    function automatic logic [20:0] mask_of(input int i);
        if (i == 11) return 21'h060000;
        return 21'h000001 << (i > 11 ? i - 1 : i);
    endfunction
    // Pulses are gathered over six cycles to catch repeats.
    task automatic cmd(input logic [15:0] a, input logic [31:0] v, input logic [20:0] exp);
        logic [20:0] acc;
        int n;
        u_mst.wr(a, v[31:16]);
        u_mst.wr(a + 16'h0001, v[15:0]);
        acc = '0;
        n = 0;
        repeat (6) begin
            @(posedge i_mclk);
            #1;
            acc |= p;
            n += int'(|p);
        end
        chk(acc, exp);
        chk(n, exp != 0);
    endtask
    initial begin
        repeat (20000) @(posedge i_mclk);
        err_count++;
        results;
    end
    initial begin
        logic [15:0] d;
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 21; i++) begin
            cmd(OFS[i], 32'h1, mask_of(i));
            cmd(OFS[i], 32'h1, '0);
            u_mst.rd(OFS[i] + 16'h0001, d);
            chk(d, 16'h0001);
            cmd(OFS[i], 32'h2, mask_of(i));
            cmd(OFS[i], 32'h2, mask_of(i));
            u_mst.rd(OFS[i] + 16'h0001, d);
            chk(d, 16'h0001);
        end
        chk(nidx, 4'ha);
        chk(mask, 10'h3ff);
        $display("trigger methods test done");
        cmd(16'h0180, 32'h0, '0);
        cmd(16'h0180, 32'h1, 21'h1);
        @(posedge i_mclk);
        nonres <= 1'b1;
        nsel <= 4'h3;
        cmd(16'h0180, 32'h2, '0);
        u_mst.rd(16'h0182, d);
        chk(d, 16'h0000);
        for (int c = 1; c < 5; c++) begin
            cmd(16'h01be, c, 21'h100000);
            chk(method, c);
            chk(keep, c == 3);
            u_mst.rd(16'h01bf, d);
            chk(d, 16'h0000);
        end
        cmd(16'h01be, 32'h5, '0);
        cmd(16'h01bc, 32'h2, 21'h080000);
        chk(nidx, 4'h3);
        $display("halt and alarm test done");
        results;
    end
endmodule // test_maintenance_command_trigger
bind mct_cmd_bank mct_cmd_bank_sva #(.LINK_PARAM_COUNT(LINK_PARAM_COUNT)) u_sva (.*);
